// *** core/video_switch_aux_config_regs.sv ***
// Two-wire serial slave and pin handling for the auxiliary configuration registers
`timescale 1ns/1ps
`include "video_switch_cfg.svh"
// Behaviour
// - Termination source: 0000 automatic, 1111 manual
// - Manual mask bits enable inputs A..D
// - Buffer enable bits; register resets to 0x07
// - Hot-plug pulse equals length times step
// - Source bit selects automatic or manual hot-plug
// - Manual mask bits pull hot-plug outputs low
// - Loss enable bit and threshold select field
// - Autosquelch bit; reserved bit written zero
// - Replicator mode bit stops replicator when set
// - Key 0x96 unlocks EEPROM, 0x00 locks
// - Loss flags per input, zero while detection is disabled
// - Slave address 10010 plus two pins
module video_switch_aux_config_regs
   import video_switch_pkg::*;
#(
   parameter int         STEP_CYCLES    = `HP_STEP_CYCLES,
   // Identification values are arbitrary
   parameter logic [7:0] REVISION_VALUE = 8'h11,
   parameter logic [7:0] DEVICE_VALUE   = 8'h5A
) (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // Serial bus pins
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic [1:0] addr_sel,
   // Channel switch events
   input  wire logic       chan_switch,
   input  wire logic [1:0] chan_sel,
   // Loss detectors, one per input
   input  wire logic [3:0] loss_raw,
   // Input terminations
   output logic [3:0]      term_on,
   // Auxiliary buffers
   output logic            display_link_buffer_on,
   output logic            consumer_ctrl_buffer_on,
   // Hot-plug open-drain outputs, bit 0 is input A
   output logic [3:0]      hotplug_out,
   output logic [3:0]      hotplug_oe,
   // Loss detection and squelch settings
   output logic            loss_detect_on,
   output logic [1:0]      loss_threshold_sel,
   output logic            autosquelch_on,
   // Replicator and EEPROM protection
   output logic            replicator_off_bit,
   output logic            eeprom_write_ok
);
   reg_access_if bus ();

   // Pin synchronisers; third stage only for edge detection
   logic       scl_m_q, scl_s_q, scl_p_q;
   logic       sda_m_q, sda_s_q, sda_p_q;
   logic [1:0] addr_m_q, addr_s_q;
   logic [3:0] loss_m_q, loss_s_q;
   logic       scl_m_d, scl_s_d, scl_p_d;
   logic       sda_m_d, sda_s_d, sda_p_d;
   logic [1:0] addr_m_d, addr_s_d;
   logic [3:0] loss_m_d, loss_s_d;

   always_comb begin
      scl_m_d  = scl_in;
      scl_s_d  = scl_m_q;
      scl_p_d  = scl_s_q;
      sda_m_d  = sda_in;
      sda_s_d  = sda_m_q;
      sda_p_d  = sda_s_q;
      addr_m_d = addr_sel;
      addr_s_d = addr_m_q;
      loss_m_d = loss_raw;
      loss_s_d = loss_m_q;
   end

   // Bus idles high so clock and data synchronisers reset to one
   always_ff @(posedge mclk) begin
      if (rst) begin
         scl_m_q  <= 1'b1;
         scl_s_q  <= 1'b1;
         scl_p_q  <= 1'b1;
         sda_m_q  <= 1'b1;
         sda_s_q  <= 1'b1;
         sda_p_q  <= 1'b1;
         addr_m_q <= 2'h0;
         addr_s_q <= 2'h0;
         loss_m_q <= 4'h0;
         loss_s_q <= 4'h0;
      end else begin
         scl_m_q  <= scl_m_d;
         scl_s_q  <= scl_s_d;
         scl_p_q  <= scl_p_d;
         sda_m_q  <= sda_m_d;
         sda_s_q  <= sda_s_d;
         sda_p_q  <= sda_p_d;
         addr_m_q <= addr_m_d;
         addr_s_q <= addr_s_d;
         loss_m_q <= loss_m_d;
         loss_s_q <= loss_s_d;
      end
   end

   logic scl_rise, scl_fall, bus_start, bus_stop;

   assign scl_rise  = scl_s_q & ~scl_p_q;
   assign scl_fall  = ~scl_s_q & scl_p_q;
   assign bus_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
   assign bus_stop  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

   // Serial engine
   serial_state_type st_q, st_d;
   logic [3:0]       cnt_q, cnt_d;
   logic [7:0]       shift_q, shift_d;
   logic [7:0]       tx_q, tx_d;
   logic [7:0]       ptr_q, ptr_d;
   logic [7:0]       wdata_q, wdata_d;
   logic             rw_q, rw_d;
   logic             nack_q, nack_d;
   logic             oe_q, oe_d;
   logic             wr_q, wr_d;

   always_comb begin
      st_d    = st_q;
      cnt_d   = cnt_q;
      shift_d = shift_q;
      tx_d    = tx_q;
      ptr_d   = ptr_q;
      wdata_d = wdata_q;
      rw_d    = rw_q;
      nack_d  = nack_q;
      oe_d    = oe_q;
      wr_d    = 1'b0;
      if (bus_start) begin
         st_d  = S_DEV;
         cnt_d = 4'h0;
         oe_d  = 1'b0;
      end else if (bus_stop) begin
         st_d = S_IDLE;
         oe_d = 1'b0;
      end else if (scl_rise) begin
         case (st_q)
            S_DEV, S_PTR, S_WDATA: begin
               shift_d = {shift_q[6:0], sda_s_q};
               cnt_d   = cnt_q + 4'h1;
            end
            S_RDATA: cnt_d = cnt_q + 4'h1;
            S_MACK:  nack_d = sda_s_q;
            default: ;
         endcase
      end else if (scl_fall) begin
         case (st_q)
            S_DEV: begin
               if (cnt_q == 4'h8) begin
                  // Only our own address is answered
                  if (shift_q[7:1] == {`SLAVE_ADDR_HI, addr_s_q}) begin
                     st_d = S_ACK_DEV;
                     rw_d = shift_q[0];
                     oe_d = 1'b1;
                  end else begin
                     st_d = S_IDLE;
                  end
               end
            end
            S_ACK_DEV: begin
               cnt_d = 4'h0;
               if (rw_q) begin
                  st_d = S_RDATA;
                  tx_d = bus.rdata;
                  oe_d = ~bus.rdata[7];
               end else begin
                  st_d = S_PTR;
                  oe_d = 1'b0;
               end
            end
            S_PTR: begin
               if (cnt_q == 4'h8) begin
                  ptr_d = shift_q;
                  st_d  = S_ACK_PTR;
                  oe_d  = 1'b1;
               end
            end
            S_ACK_PTR, S_ACK_WDATA: begin
               st_d  = S_WDATA;
               cnt_d = 4'h0;
               oe_d  = 1'b0;
            end
            S_WDATA: begin
               if (cnt_q == 4'h8) begin
                  wdata_d = shift_q;
                  wr_d    = 1'b1;
                  st_d    = S_ACK_WDATA;
                  oe_d    = 1'b1;
               end
            end
            S_RDATA: begin
               if (cnt_q == 4'h8) begin
                  // Release for the master's acknowledge
                  st_d  = S_MACK;
                  oe_d  = 1'b0;
                  ptr_d = ptr_q + 8'h01;
               end else begin
                  tx_d = {tx_q[6:0], 1'b0};
                  oe_d = ~tx_q[6];
               end
            end
            S_MACK: begin
               cnt_d = 4'h0;
               if (nack_q) begin
                  st_d = S_IDLE;
               end else begin
                  st_d = S_RDATA;
                  tx_d = bus.rdata;
                  oe_d = ~bus.rdata[7];
               end
            end
            default: ;
         endcase
      end
      // Pointer advances after each written byte
      if (wr_q) begin
         ptr_d = ptr_q + 8'h01;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st_q    <= S_IDLE;
         cnt_q   <= 4'h0;
         shift_q <= 8'h00;
         tx_q    <= 8'h00;
         ptr_q   <= 8'h00;
         wdata_q <= 8'h00;
         rw_q    <= 1'b0;
         nack_q  <= 1'b1;
         oe_q    <= 1'b0;
         wr_q    <= 1'b0;
      end else begin
         st_q    <= st_d;
         cnt_q   <= cnt_d;
         shift_q <= shift_d;
         tx_q    <= tx_d;
         ptr_q   <= ptr_d;
         wdata_q <= wdata_d;
         rw_q    <= rw_d;
         nack_q  <= nack_d;
         oe_q    <= oe_d;
         wr_q    <= wr_d;
      end
   end

   // Open-drain pins only ever pull low
   logic low_q;

   always_ff @(posedge mclk) begin
      low_q <= 1'b0;
   end

   assign bus.addr    = ptr_q;
   assign bus.wdata   = wdata_q;
   assign bus.wr      = wr_q;
   assign sda_out     = low_q;
   assign sda_oe      = oe_q;
   assign hotplug_out = {4{low_q}};

   aux_reg_bank #(
      .STEP_CYCLES    (STEP_CYCLES),
      .REVISION_VALUE (REVISION_VALUE),
      .DEVICE_VALUE   (DEVICE_VALUE)
   ) u_bank (
      .mclk                    (mclk),
      .rst                     (rst),
      .bus                     (bus.bank),
      .chan_switch             (chan_switch),
      .chan_sel                (chan_sel),
      .loss_sync               (loss_s_q),
      .term_on                 (term_on),
      .display_link_buffer_on  (display_link_buffer_on),
      .consumer_ctrl_buffer_on (consumer_ctrl_buffer_on),
      .hotplug_oe              (hotplug_oe),
      .loss_detect_on          (loss_detect_on),
      .loss_threshold_sel      (loss_threshold_sel),
      .autosquelch_on          (autosquelch_on),
      .replicator_off_bit      (replicator_off_bit),
      .eeprom_write_ok         (eeprom_write_ok)
   );
endmodule : video_switch_aux_config_regs

// *** core/video_switch_cfg.svh ***
// Offsets, field positions, reset values and timing for the auxiliary register bank
`ifndef VIDEO_SWITCH_CFG_SVH
`define VIDEO_SWITCH_CFG_SVH
`define OFS_TERM_CTRL     8'h03
`define OFS_AUX_ENABLES   8'h04
`define OFS_HP_WIDTH      8'h05
`define OFS_HP_OVERRIDE   8'h06
`define OFS_LOSS_CTRL     8'h07
`define OFS_REPL_MODE     8'h0E
`define OFS_UNLOCK        8'h0F
`define OFS_LOSS_FLAGS    8'h10
`define OFS_REVISION      8'hFE
`define OFS_DEVICE        8'hFF
`define RST_TERM_CTRL     8'h0F
`define RST_AUX_ENABLES   3'h7
`define RST_HP_WIDTH      8'h05
`define RST_HP_OVERRIDE   5'h00
`define RST_LOSS_CTRL     6'h00
`define RST_UNLOCK        8'h00
`define TERM_MANUAL_SRC   4'hF
`define HP_SRC_BIT        4
`define LOSS_EN_BIT       0
`define LOSS_RSVD_BIT     1
`define SQUELCH_BIT       2
`define LOSS_THR_LSB      4
`define DISPLAY_BUF_BIT   1
`define CONSUMER_BUF_BIT  0
`define UNLOCK_KEY        8'h96
`define SLAVE_ADDR_HI     5'h12
`define CLK_KHZ           20000
`define HP_STEP_MS        24
`define HP_STEP_CYCLES    (`HP_STEP_MS * `CLK_KHZ)
`endif

// *** core/video_switch_pkg.sv ***
// Types and shared helpers for the video switch auxiliary register bank
package video_switch_pkg;
   typedef enum logic [3:0] {
      S_IDLE, S_DEV, S_ACK_DEV, S_PTR, S_ACK_PTR, S_WDATA, S_ACK_WDATA, S_RDATA, S_MACK
   } serial_state_type;

   function automatic logic [3:0] onehot4(input logic [1:0] sel);
      onehot4 = 4'h1 << sel;
   endfunction : onehot4
endpackage : video_switch_pkg

// *** core/reg_access_if.sv ***
// Register access path between the serial engine and the register bank
`timescale 1ns/1ps
interface reg_access_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic [7:0] rdata;
   modport engine (output addr, output wdata, output wr, input rdata);
   modport bank (input addr, input wdata, input wr, output rdata);
endinterface : reg_access_if

// *** core/aux_reg_bank.sv ***
// Register storage, hot-plug pulse timer and derived control outputs
`timescale 1ns/1ps
`include "video_switch_cfg.svh"
module aux_reg_bank
   import video_switch_pkg::*;
#(
   parameter int         STEP_CYCLES    = `HP_STEP_CYCLES,
   // Identification values are arbitrary
   parameter logic [7:0] REVISION_VALUE = 8'h11,
   parameter logic [7:0] DEVICE_VALUE   = 8'h5A
) (
   input  wire logic       mclk,
   input  wire logic       rst,
   reg_access_if.bank      bus,
   input  wire logic       chan_switch,
   input  wire logic [1:0] chan_sel,
   input  wire logic [3:0] loss_sync,
   output logic [3:0]      term_on,
   output logic            display_link_buffer_on,
   output logic            consumer_ctrl_buffer_on,
   output logic [3:0]      hotplug_oe,
   output logic            loss_detect_on,
   output logic [1:0]      loss_threshold_sel,
   output logic            autosquelch_on,
   output logic            replicator_off_bit,
   output logic            eeprom_write_ok
);
   localparam int CW = $clog2(STEP_CYCLES + 1);

   logic [7:0]    term_q, term_d, hp_len_q, hp_len_d, key_q, key_d, rdata_q, rdata_d;
   logic [2:0]    aux_q, aux_d;
   logic [4:0]    hp_ovr_q, hp_ovr_d;
   logic [5:0]    loss_q, loss_d;
   logic          repl_q, repl_d, busy_q, busy_d, unlock_q, unlock_d;
   logic [3:0]    flags_q, flags_d, term_out_q, term_out_d, hp_oe_q, hp_oe_d;
   logic [1:0]    hp_ch_q, hp_ch_d;
   logic [7:0]    steps_q, steps_d;
   logic [CW-1:0] cyc_q, cyc_d;

   always_comb begin
      term_d   = term_q;
      aux_d    = aux_q;
      hp_len_d = hp_len_q;
      hp_ovr_d = hp_ovr_q;
      loss_d   = loss_q;
      repl_d   = repl_q;
      key_d    = key_q;
      // Unused bits are dropped on write
      if (bus.wr) begin
         case (bus.addr)
            `OFS_TERM_CTRL:   term_d   = bus.wdata;
            `OFS_AUX_ENABLES: aux_d    = bus.wdata[2:0];
            `OFS_HP_WIDTH:    hp_len_d = bus.wdata;
            `OFS_HP_OVERRIDE: hp_ovr_d = bus.wdata[4:0];
            `OFS_LOSS_CTRL:   loss_d   = {bus.wdata[5:4], 1'b0, bus.wdata[2:0]};
            `OFS_REPL_MODE:   repl_d   = bus.wdata[0];
            `OFS_UNLOCK:      key_d    = bus.wdata;
            default:          ;
         endcase
      end
      // Compare ahead of the flop so the unlock pin is registered
      unlock_d = (key_d == `UNLOCK_KEY);
      // Flags reflect detectors only while detection is enabled
      flags_d = loss_q[`LOSS_EN_BIT] ? loss_sync : 4'h0;
      case (bus.addr)
         `OFS_TERM_CTRL:   rdata_d = term_q;
         `OFS_AUX_ENABLES: rdata_d = {5'h00, aux_q};
         `OFS_HP_WIDTH:    rdata_d = hp_len_q;
         `OFS_HP_OVERRIDE: rdata_d = {3'h0, hp_ovr_q};
         `OFS_LOSS_CTRL:   rdata_d = {2'h0, loss_q};
         `OFS_LOSS_FLAGS:  rdata_d = {4'h0, flags_q};
         `OFS_REVISION:    rdata_d = REVISION_VALUE;
         `OFS_DEVICE:      rdata_d = DEVICE_VALUE;
         default:          rdata_d = 8'h00;
      endcase
   end

   // Pulse lasts hotplug_pulse_len steps; a new switch restarts it
   always_comb begin
      busy_d  = busy_q;
      hp_ch_d = hp_ch_q;
      steps_d = steps_q;
      cyc_d   = cyc_q;
      if (chan_switch && hp_len_q != 8'h00) begin
         busy_d  = 1'b1;
         hp_ch_d = chan_sel;
         steps_d = hp_len_q;
         cyc_d   = CW'(STEP_CYCLES - 1);
      end else if (busy_q) begin
         if (cyc_q == '0) begin
            cyc_d   = CW'(STEP_CYCLES - 1);
            steps_d = steps_q - 8'h01;
            busy_d  = (steps_q != 8'h01);
         end else begin
            cyc_d = cyc_q - 1'b1;
         end
      end
      if (hp_ovr_q[`HP_SRC_BIT]) begin
         hp_oe_d = hp_ovr_q[3:0];
      end else begin
         hp_oe_d = busy_q ? onehot4(hp_ch_q) : 4'h0;
      end
      if (term_q[7:4] == `TERM_MANUAL_SRC) begin
         term_out_d = term_q[3:0];
      end else begin
         term_out_d = onehot4(chan_sel);
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         term_q     <= `RST_TERM_CTRL;
         aux_q      <= `RST_AUX_ENABLES;
         hp_len_q   <= `RST_HP_WIDTH;
         hp_ovr_q   <= `RST_HP_OVERRIDE;
         loss_q     <= `RST_LOSS_CTRL;
         repl_q     <= 1'b0;
         key_q      <= `RST_UNLOCK;
         unlock_q   <= 1'b0;
         rdata_q    <= 8'h00;
         flags_q    <= 4'h0;
         busy_q     <= 1'b0;
         hp_ch_q    <= 2'h0;
         steps_q    <= 8'h00;
         cyc_q      <= '0;
         hp_oe_q    <= 4'h0;
         term_out_q <= 4'h0;
      end else begin
         term_q     <= term_d;
         aux_q      <= aux_d;
         hp_len_q   <= hp_len_d;
         hp_ovr_q   <= hp_ovr_d;
         loss_q     <= loss_d;
         repl_q     <= repl_d;
         key_q      <= key_d;
         unlock_q   <= unlock_d;
         rdata_q    <= rdata_d;
         flags_q    <= flags_d;
         busy_q     <= busy_d;
         hp_ch_q    <= hp_ch_d;
         steps_q    <= steps_d;
         cyc_q      <= cyc_d;
         hp_oe_q    <= hp_oe_d;
         term_out_q <= term_out_d;
      end
   end

   assign bus.rdata               = rdata_q;
   assign term_on                 = term_out_q;
   assign display_link_buffer_on  = aux_q[`DISPLAY_BUF_BIT];
   assign consumer_ctrl_buffer_on = aux_q[`CONSUMER_BUF_BIT];
   assign hotplug_oe              = hp_oe_q;
   assign loss_detect_on          = loss_q[`LOSS_EN_BIT];
   assign loss_threshold_sel      = loss_q[`LOSS_THR_LSB +: 2];
   assign autosquelch_on          = loss_q[`SQUELCH_BIT];
   assign replicator_off_bit      = repl_q;
   assign eeprom_write_ok         = unlock_q;
endmodule : aux_reg_bank

// *** tb/video_switch_aux_config_regs_props.sv ***
// Pin-level checks on the auxiliary register bank
`timescale 1ns/1ps
module video_switch_aux_config_regs_props (
   // Clock and reset
   input wire logic       mclk,
   input wire logic       rst,
   // Serial bus and channel events
   input wire logic       scl_in,
   input wire logic       sda_out,
   input wire logic       sda_oe,
   input wire logic       chan_switch,
   input wire logic [1:0] chan_sel,
   // Controlled outputs
   input wire logic [3:0] term_on,
   input wire logic       display_link_buffer_on,
   input wire logic       consumer_ctrl_buffer_on,
   input wire logic [3:0] hotplug_out,
   input wire logic [3:0] hotplug_oe,
   input wire logic       loss_detect_on,
   input wire logic [1:0] loss_threshold_sel,
   input wire logic       autosquelch_on,
   input wire logic       replicator_off_bit,
   input wire logic       eeprom_write_ok
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_rst_exit;
      rst ##1 !rst;
   endsequence
   property p_open_drain;
      sda_out == 1'b0 && hotplug_out == 4'h0;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("open-drain data not low");
   property p_rst_buffers;
      disable iff (1'b0) rst |=> display_link_buffer_on && consumer_ctrl_buffer_on;
   endproperty
   a_rst_buffers: assert property (p_rst_buffers) else $error("buffers off after reset");
   property p_rst_loss;
      disable iff (1'b0) rst |=> !loss_detect_on && loss_threshold_sel == 2'h0 && !autosquelch_on;
   endproperty
   a_rst_loss: assert property (p_rst_loss) else $error("loss settings after reset");
   property p_rst_lock;
      disable iff (1'b0) rst |=> !replicator_off_bit && !eeprom_write_ok && hotplug_oe == 4'h0;
   endproperty
   a_rst_lock: assert property (p_rst_lock) else $error("protection after reset");
   property p_term_reset;
      disable iff (1'b0) s_rst_exit |-> ##2 term_on == (4'h1 << $past(chan_sel));
   endproperty
   a_term_reset: assert property (p_term_reset) else $error("terminations after reset");
   // Outside bus writes only the selected input may take the termination
   property p_term_follow;
      $changed(term_on) |-> !$past(scl_in) || term_on == (4'h1 << $past(chan_sel))
         || $past(rst, 2) || $past(rst, 3);
   endproperty
   a_term_follow: assert property (p_term_follow) else $error("termination change");
   property p_cfg_quiet;
      $changed({display_link_buffer_on, consumer_ctrl_buffer_on, loss_detect_on,
         loss_threshold_sel, autosquelch_on, replicator_off_bit, eeprom_write_ok})
         |-> !scl_in && !$past(scl_in);
   endproperty
   a_cfg_quiet: assert property (p_cfg_quiet) else $error("setting changed off a write");
   property p_ack_phase;
      $changed(sda_oe) |-> !scl_in;
   endproperty
   a_ack_phase: assert property (p_ack_phase) else $error("data moved while clock high");
   property p_hp_cause;
      (hotplug_oe & ~$past(hotplug_oe)) != 4'h0
         |-> $past(chan_switch, 2) || $past(chan_switch, 3) || !$past(scl_in);
   endproperty
   a_hp_cause: assert property (p_hp_cause) else $error("hot-plug low without cause");
endmodule : video_switch_aux_config_regs_props

bind video_switch_aux_config_regs video_switch_aux_config_regs_props u_props (
   .mclk(mclk), .rst(rst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .chan_switch(chan_switch), .chan_sel(chan_sel), .term_on(term_on),
   .display_link_buffer_on(display_link_buffer_on),
   .consumer_ctrl_buffer_on(consumer_ctrl_buffer_on), .hotplug_out(hotplug_out),
   .hotplug_oe(hotplug_oe), .loss_detect_on(loss_detect_on),
   .loss_threshold_sel(loss_threshold_sel), .autosquelch_on(autosquelch_on),
   .replicator_off_bit(replicator_off_bit), .eeprom_write_ok(eeprom_write_ok));

// *** tb/serial_master_model.sv ***
// Two-wire bus master driving the serial pins
`timescale 1ns/1ps
`include "video_switch_cfg.svh"
module serial_master_model (
   // Clock and bus lines
   input  wire logic mclk,
   output logic      scl,
   output logic      sda_m,
   input  wire logic sda
);
   initial begin
      scl   = 1'b1;
      sda_m = 1'b1;
   end
   // Eight cycles per phase, longer than the slave's synchronisers need
   task automatic ph();
      repeat (8) @(posedge mclk);
      #1;
   endtask : ph
   // Data moves two cycles after the fall to keep hold time
   task automatic bit_io(input logic b, output logic r);
      repeat (2) @(posedge mclk);
      #1 sda_m = b;
      ph();
      scl = 1'b1;
      ph();
      r   = sda;
      scl = 1'b0;
   endtask : bit_io
   task automatic start();
      sda_m = 1'b1;
      ph();
      scl = 1'b1;
      ph();
      sda_m = 1'b0;
      ph();
      scl = 1'b0;
   endtask : start
   task automatic stop();
      repeat (2) @(posedge mclk);
      #1 sda_m = 1'b0;
      ph();
      scl = 1'b1;
      ph();
      sda_m = 1'b1;
      ph();
   endtask : stop
   task automatic xbyte(input logic [7:0] v, output logic [7:0] r, output logic nak);
      for (int i = 7; i >= 0; i--) bit_io(v[i], r[i]);
      bit_io(1'b1, nak);
   endtask : xbyte
   task automatic xfer(input logic [1:0] as, input logic [7:0] p, input logic [7:0] v,
                       input logic rd, output logic [7:0] d, output logic ok);
      logic [7:0] r;
      logic [3:0] n;
      start();
      xbyte({`SLAVE_ADDR_HI, as, 1'b0}, r, n[0]);
      xbyte(p, r, n[1]);
      if (rd) begin
         start();
         xbyte({`SLAVE_ADDR_HI, as, 1'b1}, r, n[2]);
         xbyte(8'hFF, d, n[3]);
      end else begin
         xbyte(v, r, n[2]);
      end
      stop();
      ok = (n[2:0] == 3'h0);
   endtask : xfer
endmodule : serial_master_model

// *** tb/video_switch_aux_config_regs_test.sv ***
// Self-checking bench for the auxiliary configuration register bank
`timescale 1ns/1ps
module video_switch_aux_config_regs_test;
   localparam int STEP = 10;
   logic       mclk        = 1'b0;
   logic       rst         = 1'b1;
   logic [1:0] addr_sel    = 2'h1;
   logic       chan_switch = 1'b0;
   logic [1:0] chan_sel    = 2'h0;
   logic [3:0] loss_raw    = 4'h0;
   logic       scl, sda_m, sda, sda_out, sda_oe, dbuf, cbuf, loss_on, squelch, repl, unl, ok;
   logic [3:0] term_on, hp_out, hp_oe;
   logic [1:0] thr;
   logic [7:0] rv, d, v;
   int         fail_count  = 0;
   int         checks_done = 0;
   int         seed        = 32'h27C29286;
   logic [7:0] ofs [11] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0E, 8'h0F, 8'h10,
                            8'hFE, 8'hFF, 8'h20};
   logic [7:0] dfl [11] = '{8'h0F, 8'h07, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                            8'h11, 8'h5A, 8'h00};
   logic [7:0] hpv [5]  = '{8'h11, 8'h18, 8'h1F, 8'h10, 8'h0F};
   logic [3:0] lsv [4]  = '{4'h0, 4'h1, 4'h8, 4'hF};

   always #25 mclk = ~mclk;
   // Pull-up on the shared data line
   assign sda = sda_m & ~sda_oe;

   serial_master_model u_host (.mclk(mclk), .scl(scl), .sda_m(sda_m), .sda(sda));
   video_switch_aux_config_regs #(.STEP_CYCLES(STEP)) u_dut (
      .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .addr_sel(addr_sel), .chan_switch(chan_switch), .chan_sel(chan_sel),
      .loss_raw(loss_raw), .term_on(term_on), .display_link_buffer_on(dbuf),
      .consumer_ctrl_buffer_on(cbuf), .hotplug_out(hp_out), .hotplug_oe(hp_oe),
      .loss_detect_on(loss_on), .loss_threshold_sel(thr), .autosquelch_on(squelch),
      .replicator_off_bit(repl), .eeprom_write_ok(unl));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   function automatic logic [3:0] exp_term(input logic [7:0] r, input logic [1:0] s);
      exp_term = (r[7:4] == 4'hF) ? r[3:0] : (4'h1 << s);
   endfunction : exp_term
   task automatic wr(input logic [7:0] p, input logic [7:0] x);
      u_host.xfer(addr_sel, p, x, 1'b0, rv, ok);
      chk({7'h0, ok}, 8'h01);
   endtask : wr
   task automatic rd(input logic [7:0] p, input logic [7:0] e);
      u_host.xfer(addr_sel, p, 8'h00, 1'b1, rv, ok);
      chk({7'h0, ok}, 8'h01);
      chk(rv, e);
   endtask : rd
   // Channel change, then count cycles with the new input held low
   task automatic swap(input logic [1:0] s, input int len);
      int cnt;
      cnt = 0;
      chan_sel = s;
      chan_switch = 1'b1;
      @(posedge mclk);
      #1 chan_switch = 1'b0;
      repeat (len * STEP + 20) begin
         @(posedge mclk);
         #1 cnt += (hp_oe === (4'h1 << s)) ? 1 : 0;
      end
      chk({4'h0, term_on}, {4'h0, exp_term(8'h00, s)});
      chk({7'h0, cnt >= len * STEP - 1 && cnt <= len * STEP + 1}, 8'h01);
   endtask : swap
   task automatic end_sim();
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim

   initial begin
      repeat (95000) @(posedge mclk);
      fail_count++;
      end_sim();
   end

   initial begin
      repeat (8) @(posedge mclk);
      #1 rst = 1'b0;
      repeat (4) @(posedge mclk);
      #1 chk({dbuf, cbuf, 2'h0, term_on}, {2'h3, 2'h0, exp_term(8'h0F, chan_sel)});
      for (int i = 0; i < 11; i++) rd(ofs[i], dfl[i]);
      $display("test reset_values done");
      for (int n = 0; n < 4; n++) begin
         d = (n == 0) ? 8'hF0 : 8'($random(seed));
         d[7:4] = {4{d[7]}};
         chan_sel = d[1:0] ^ d[3:2];
         wr(8'h03, d);
         chk({4'h0, term_on}, {4'h0, exp_term(d, chan_sel)});
         wr(8'h04, d | 8'h04);
         chk({6'h0, dbuf, cbuf}, {6'h0, d[1:0]});
         rd(8'h04, (d & 8'h03) | 8'h04);
         wr(8'h07, d & 8'hFD);
         chk({2'h0, thr, 1'h0, squelch, 1'h0, loss_on}, d & 8'h35);
         rd(8'h07, d & 8'h35);
      end
      wr(8'hFE, 8'h00);
      rd(8'hFE, 8'h11);
      $display("test random_settings done");
      for (int i = 0; i < 5; i++) begin
         v = hpv[i];
         wr(8'h06, v);
         chk({4'h0, hp_oe}, {4'h0, v[4] ? v[3:0] : 4'h0});
      end
      $display("test hotplug_manual done");
      wr(8'h03, 8'h00);
      wr(8'h05, 8'h03);
      for (int s = 0; s < 4; s++) swap(2'(s), 3);
      wr(8'h05, 8'h00);
      swap(2'h2, 0);
      $display("test hotplug_auto done");
      wr(8'h0E, 8'h01);
      chk({6'h0, repl, unl}, 8'h02);
      rd(8'h0E, 8'h00);
      wr(8'h0E, 8'h00);
      wr(8'h0F, 8'h96);
      chk({6'h0, repl, unl}, 8'h01);
      rd(8'h0F, 8'h00);
      wr(8'h0F, 8'h00);
      chk({6'h0, repl, unl}, 8'h00);
      $display("test write_only done");
      wr(8'h07, 8'h00);
      loss_raw = 4'hF;
      rd(8'h10, 8'h00);
      wr(8'h07, 8'h01);
      for (int i = 0; i < 5; i++) begin
         loss_raw = (i == 4) ? 4'($random(seed)) : lsv[i];
         rd(8'h10, {4'h0, loss_raw});
      end
      $display("test loss_flags done");
      u_host.xfer(~addr_sel, 8'h04, 8'h00, 1'b0, rv, ok);
      chk({7'h0, ok}, 8'h00);
      addr_sel = 2'h2;
      wr(8'h04, 8'h05);
      chk({6'h0, dbuf, cbuf}, 8'h01);
      $display("test address_match done");
      end_sim();
   end
endmodule : video_switch_aux_config_regs_test
